// ---- cpu_register_set_pkg.sv ----
// Shared types and constants for the processor register set
//
// Functional notes
// - External interrupt vector table base register provided.
// - Separate internal interrupt vector base register.
// - Byte accumulator; word accumulator or index substitutes.
// - Flags reachable only through stack push/pop.
// - Four spare flag bits stored and returned.
// - Operations update flags; jumps test them.
// - Pointer registers hold 16-bit logical addresses.
// - Stack pointer register for linkage and storage.
// - Accumulator-flags exchange swaps with alternate copy.
// - Bank exchange swaps three pairs at once.
// - Priority history: four 2-bit fields.
// - Four priority levels in each field.
package cpu_register_set_pkg;

  localparam int BYTE_W      = 8;
  localparam int WORD_W      = 16;
  localparam int LEVEL_W     = 2;
  localparam int HIST_FIELDS = 4;

  // Flag bit positions; bits 5, 4, 3 and 1 are spare
  localparam int FLAG_SIGN  = 7;
  localparam int FLAG_ZERO  = 6;
  localparam int FLAG_OVFL  = 2;
  localparam int FLAG_CARRY = 0;
  localparam logic [7:0] FLAG_SPARE_MASK = 8'h3A;

  localparam logic [7:0]  ACC_RESET   = 8'h00;
  localparam logic [7:0]  FLAGS_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET  = 16'h0000;
  localparam logic [15:0] SP_RESET    = 16'h0000;
  localparam logic [7:0]  VEC_RESET   = 8'h00;
  localparam logic [7:0]  HIST_RESET  = 8'hFF;

  typedef enum logic [3:0] {
    OP_NONE       = 4'h0,
    OP_WRITE      = 4'h1,
    OP_SWAP_AF    = 4'h2,
    OP_SWAP_BANK  = 4'h3,
    OP_STACK_SAVE_ACCUM_FLAGS    = 4'h4,
    OP_STACK_LOAD_ACCUM_FLAGS     = 4'h5,
    OP_ALU_FLAGS  = 4'h6,
    OP_PRI_RAISE  = 4'h7,
    OP_PRI_RESTORE = 4'h8
  } op_e;

  typedef enum logic [3:0] {
    SEL_ACCUM          = 4'h0,
    SEL_WIDE_ACCUM     = 4'h1,
    SEL_PAIR_SECOND    = 4'h2,
    SEL_PAIR_THIRD     = 4'h3,
    SEL_INDEX_FIRST    = 4'h4,
    SEL_INDEX_SECOND   = 4'h5,
    SEL_STACK_POINTER  = 4'h6,
    SEL_EXT_VEC        = 4'h7,
    SEL_INT_VEC        = 4'h8,
    SEL_PRI_HIST       = 4'h9
  } reg_sel_e;

  typedef enum logic [2:0] {
    CC_NZ = 3'h0,
    CC_Z  = 3'h1,
    CC_NC = 3'h2,
    CC_C  = 3'h3,
    CC_NV = 3'h4,
    CC_V  = 3'h5,
    CC_P  = 3'h6,
    CC_M  = 3'h7
  } cond_e;

  typedef struct packed {
    op_e                op;
    reg_sel_e           sel;
    logic [15:0]        data;
    logic [7:0]         flag_mask;
    logic [7:0]         flag_value;
    logic [LEVEL_W-1:0] level;
    cond_e              cond;
  } cmd_s;

  typedef struct packed {
    logic [7:0]  accum;
    logic [15:0] wide_accumulator;
    logic [15:0] pair_second;
    logic [15:0] pair_third;
    logic [15:0] index_first;
    logic [15:0] index_second;
    logic [15:0] stack_pointer;
    logic [7:0]  external_vector_base;
    logic [7:0]  internal_vector_base;
    logic [7:0]  priority_history;
  } regs_s;

endpackage

// ---- cpu_register_set.sv ----
// Architectural register set with alternate bank and priority history
`timescale 1ns/100ps
module cpu_register_set
(
  input  wire logic                        sys_clk,
  input  wire logic                        rst,
  input  wire cpu_register_set_pkg::cmd_s  cmd,
  output wire cpu_register_set_pkg::regs_s regs,
  output wire logic [15:0]                 stack_word,
  output wire logic                        cond_true
);
  import cpu_register_set_pkg::*;

  // Primary and alternate bank state
  logic [7:0]  accum_reg,       accum_next;
  logic [7:0]  flags_reg,       flags_next;
  logic [7:0]  alt_accum_reg,   alt_accum_next;
  logic [7:0]  alt_flags_reg,   alt_flags_next;
  logic [15:0] wide_reg,        wide_next;
  logic [15:0] second_reg,      second_next;
  logic [15:0] third_reg,       third_next;
  logic [15:0] alt_wide_reg,    alt_wide_next;
  logic [15:0] alt_second_reg,  alt_second_next;
  logic [15:0] alt_third_reg,   alt_third_next;
  logic [15:0] index_a_reg,     index_a_next;
  logic [15:0] index_b_reg,     index_b_next;
  logic [15:0] sp_reg,          sp_next;
  logic [7:0]  ext_vec_reg,     ext_vec_next;
  logic [7:0]  int_vec_reg,     int_vec_next;
  logic [7:0]  hist_reg,        hist_next;
  logic [15:0] stack_word_reg,  stack_word_next;
  logic        cond_true_reg,   cond_true_next;

  function automatic logic cond_eval(input cond_e cc, input logic [7:0] f);
    logic r;
    r = 1'b0;
    case (cc)
      CC_NZ:   r = ~f[FLAG_ZERO];
      CC_Z:    r = f[FLAG_ZERO];
      CC_NC:   r = ~f[FLAG_CARRY];
      CC_C:    r = f[FLAG_CARRY];
      CC_NV:   r = ~f[FLAG_OVFL];
      CC_V:    r = f[FLAG_OVFL];
      CC_P:    r = ~f[FLAG_SIGN];
      CC_M:    r = f[FLAG_SIGN];
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  always_comb
  begin
    accum_next      = accum_reg;
    flags_next      = flags_reg;
    alt_accum_next  = alt_accum_reg;
    alt_flags_next  = alt_flags_reg;
    wide_next       = wide_reg;
    second_next     = second_reg;
    third_next      = third_reg;
    alt_wide_next   = alt_wide_reg;
    alt_second_next = alt_second_reg;
    alt_third_next  = alt_third_reg;
    index_a_next    = index_a_reg;
    index_b_next    = index_b_reg;
    sp_next         = sp_reg;
    ext_vec_next    = ext_vec_reg;
    int_vec_next    = int_vec_reg;
    hist_next       = hist_reg;
    stack_word_next = stack_word_reg;
    cond_true_next  = cond_eval(cmd.cond, flags_reg);
    case (cmd.op)
      OP_WRITE:
      begin
        case (cmd.sel)
          SEL_ACCUM:         accum_next   = cmd.data[7:0];
          SEL_WIDE_ACCUM:    wide_next    = cmd.data;
          SEL_PAIR_SECOND:   second_next  = cmd.data;
          SEL_PAIR_THIRD:    third_next   = cmd.data;
          SEL_INDEX_FIRST:   index_a_next = cmd.data;
          SEL_INDEX_SECOND:  index_b_next = cmd.data;
          SEL_STACK_POINTER: sp_next      = cmd.data;
          SEL_EXT_VEC:       ext_vec_next = cmd.data[7:0];
          SEL_INT_VEC:       int_vec_next = cmd.data[7:0];
          SEL_PRI_HIST:      hist_next    = cmd.data[7:0];
          default:           accum_next   = accum_reg;
        endcase
      end
      OP_SWAP_AF:
      begin
        accum_next     = alt_accum_reg;
        flags_next     = alt_flags_reg;
        alt_accum_next = accum_reg;
        alt_flags_next = flags_reg;
      end
      OP_SWAP_BANK:
      begin
        wide_next       = alt_wide_reg;
        second_next     = alt_second_reg;
        third_next      = alt_third_reg;
        alt_wide_next   = wide_reg;
        alt_second_next = second_reg;
        alt_third_next  = third_reg;
      end
      OP_STACK_SAVE_ACCUM_FLAGS:
      begin
        stack_word_next = {accum_reg, flags_reg};
      end
      OP_STACK_LOAD_ACCUM_FLAGS:
      begin
        accum_next = cmd.data[15:8];
        flags_next = cmd.data[7:0];
      end
      OP_ALU_FLAGS:
      begin
        flags_next = (flags_reg & ~cmd.flag_mask) | (cmd.flag_value & cmd.flag_mask);
      end
      OP_PRI_RAISE:
      begin
        // push new level in low field
        hist_next = {hist_reg[7-LEVEL_W:0], cmd.level};
      end
      OP_PRI_RESTORE:
      begin
        // restore earlier level; newest (low) field recirculates to the top
        hist_next = {hist_reg[LEVEL_W-1:0], hist_reg[7:LEVEL_W]};
      end
      default:
      begin
        accum_next = accum_reg;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      accum_reg      <= ACC_RESET;
      flags_reg      <= FLAGS_RESET;
      alt_accum_reg  <= ACC_RESET;
      alt_flags_reg  <= FLAGS_RESET;
      wide_reg       <= WORD_RESET;
      second_reg     <= WORD_RESET;
      third_reg      <= WORD_RESET;
      alt_wide_reg   <= WORD_RESET;
      alt_second_reg <= WORD_RESET;
      alt_third_reg  <= WORD_RESET;
      index_a_reg    <= WORD_RESET;
      index_b_reg    <= WORD_RESET;
      sp_reg         <= SP_RESET;
      ext_vec_reg    <= VEC_RESET;
      int_vec_reg    <= VEC_RESET;
      hist_reg       <= HIST_RESET;
      stack_word_reg <= WORD_RESET;
      cond_true_reg  <= 1'b0;
    end
    else
    begin
      accum_reg      <= accum_next;
      flags_reg      <= flags_next;
      alt_accum_reg  <= alt_accum_next;
      alt_flags_reg  <= alt_flags_next;
      wide_reg       <= wide_next;
      second_reg     <= second_next;
      third_reg      <= third_next;
      alt_wide_reg   <= alt_wide_next;
      alt_second_reg <= alt_second_next;
      alt_third_reg  <= alt_third_next;
      index_a_reg    <= index_a_next;
      index_b_reg    <= index_b_next;
      sp_reg         <= sp_next;
      ext_vec_reg    <= ext_vec_next;
      int_vec_reg    <= int_vec_next;
      hist_reg       <= hist_next;
      stack_word_reg <= stack_word_next;
      cond_true_reg  <= cond_true_next;
    end
  end

  // Flags and alternate bank are deliberately absent from the regs output
  // Whole-struct assignment; member-wise drives of a net are not taken by every tool
  assign regs = '{
    accum:                accum_reg,
    wide_accumulator:     wide_reg,
    pair_second:          second_reg,
    pair_third:           third_reg,
    index_first:          index_a_reg,
    index_second:         index_b_reg,
    stack_pointer:        sp_reg,
    external_vector_base: ext_vec_reg,
    internal_vector_base: int_vec_reg,
    priority_history:     hist_reg
  };
  assign stack_word                = stack_word_reg;
  assign cond_true                 = cond_true_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence pop_seq;
    cmd.op == OP_STACK_LOAD_ACCUM_FLAGS;
  endsequence

  sequence push_seq;
    cmd.op == OP_STACK_SAVE_ACCUM_FLAGS;
  endsequence

  sequence raise_seq;
    cmd.op == OP_PRI_RAISE;
  endsequence

  sequence restore_seq;
    cmd.op == OP_PRI_RESTORE;
  endsequence

  a_swap_af_pair: assert property (
    cmd.op == OP_SWAP_AF |=> accum_reg == $past(alt_accum_reg) && flags_reg == $past(alt_flags_reg)
      && alt_accum_reg == $past(accum_reg) && alt_flags_reg == $past(flags_reg))
    else $error("accumulator-flags exchange wrong");

  a_swap_bank_pairs: assert property (
    cmd.op == OP_SWAP_BANK |=> wide_reg == $past(alt_wide_reg) && second_reg == $past(alt_second_reg)
      && third_reg == $past(alt_third_reg) && alt_wide_reg == $past(wide_reg)
      && alt_second_reg == $past(second_reg) && alt_third_reg == $past(third_reg))
    else $error("bank exchange wrong");

  a_flags_spare_roundtrip: assert property (
    pop_seq ##1 push_seq |=> stack_word_reg == $past(cmd.data, 2))
    else $error("flags word not returned intact");

  a_flags_no_write: assert property (
    cmd.op == OP_WRITE |=> $stable(flags_reg))
    else $error("flags changed by direct write");

  a_alu_flags_update: assert property (
    cmd.op == OP_ALU_FLAGS |=>
      flags_reg == (($past(flags_reg) & ~$past(cmd.flag_mask)) | ($past(cmd.flag_value) & $past(cmd.flag_mask))))
    else $error("flag update wrong");

  a_cond_zero_test: assert property (
    cmd.cond == CC_Z && cmd.op == OP_NONE |=> cond_true_reg == $past(flags_reg[FLAG_ZERO]))
    else $error("zero condition wrong");

  a_pri_raise_shift: assert property (
    raise_seq |=> hist_reg == {$past(hist_reg[5:0]), $past(cmd.level)})
    else $error("priority raise wrong");

  a_pri_raise_restore: assert property (
    raise_seq ##1 restore_seq |=> hist_reg[5:0] == $past(hist_reg[5:0], 2) && hist_reg[7:6] == $past(cmd.level, 2))
    else $error("priority restore wrong");

  a_ext_vec_load: assert property (
    cmd.op == OP_WRITE && cmd.sel == SEL_EXT_VEC |=> ext_vec_reg == $past(cmd.data[7:0]) && $stable(int_vec_reg))
    else $error("external vector base load wrong");

  a_int_vec_load: assert property (
    cmd.op == OP_WRITE && cmd.sel == SEL_INT_VEC |=> int_vec_reg == $past(cmd.data[7:0]) && $stable(ext_vec_reg))
    else $error("internal vector base load wrong");

  a_sp_load: assert property (
    cmd.op == OP_WRITE && cmd.sel == SEL_STACK_POINTER |=> sp_reg == $past(cmd.data))
    else $error("stack pointer load wrong");

  a_accum_load: assert property (
    cmd.op == OP_WRITE && cmd.sel == SEL_ACCUM |=> accum_reg == $past(cmd.data[7:0]) && $stable(wide_reg))
    else $error("byte accumulator load wrong");

  a_index_load: assert property (
    cmd.op == OP_WRITE && cmd.sel == SEL_INDEX_FIRST |=> index_a_reg == $past(cmd.data) && $stable(wide_reg))
    else $error("index register load wrong");

  a_pop_loads_pair: assert property (
    pop_seq |=> accum_reg == $past(cmd.data[15:8]) && flags_reg == $past(cmd.data[7:0]))
    else $error("pop did not load accumulator and flags");

  a_push_captures_pair: assert property (
    push_seq |=> stack_word_reg == {$past(accum_reg), $past(flags_reg)})
    else $error("push word wrong");

  a_push_word_hold: assert property (
    cmd.op != OP_STACK_SAVE_ACCUM_FLAGS |=> $stable(stack_word_reg))
    else $error("stack word changed without push");

  a_pri_restore_rotate: assert property (
    restore_seq |=> hist_reg == {$past(hist_reg[1:0]), $past(hist_reg[7:2])})
    else $error("priority restore shift wrong");

  a_alt_af_hidden: assert property (
    cmd.op != OP_SWAP_AF |=> $stable(alt_accum_reg) && $stable(alt_flags_reg))
    else $error("alternate accumulator-flags changed without exchange");

  a_alt_bank_hidden: assert property (
    cmd.op != OP_SWAP_BANK |=> $stable(alt_wide_reg) && $stable(alt_second_reg) && $stable(alt_third_reg))
    else $error("alternate bank changed without exchange");

endmodule

// ---- testbench.sv ----
// Self-checking testbench for the processor register set
`timescale 1ns/100ps
module testbench;
  import cpu_register_set_pkg::*;
  typedef struct packed {regs_s r; logic [15:0] w; logic c;} note_s;
  logic        sys_clk;
  logic        rst;
  cmd_s        cmd;
  regs_s       regs;
  logic [15:0] stack_word;
  logic        cond_true;
  int          fail_count;
  int          cmp_count;
  note_s       notes[$];
  regs_s       m;
  logic [7:0]  mf;
  logic [15:0] alt_af;
  logic [15:0] alt_hl;
  logic [15:0] alt_de;
  logic [15:0] alt_bc;
  logic [15:0] m_sw;
  logic        m_ct;

  cpu_register_set u_dut
  (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .cmd        (cmd),
    .regs       (regs),
    .stack_word (stack_word),
    .cond_true  (cond_true)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  function automatic logic cond_eval(cond_e cc, logic [7:0] f);
    case (cc)
      CC_NZ: return !f[FLAG_ZERO];
      CC_Z:  return f[FLAG_ZERO];
      CC_NC: return !f[FLAG_CARRY];
      CC_C:  return f[FLAG_CARRY];
      CC_NV: return !f[FLAG_OVFL];
      CC_V:  return f[FLAG_OVFL];
      CC_P:  return !f[FLAG_SIGN];
      default: return f[FLAG_SIGN];
    endcase
  endfunction

  task model_reset;
    m = '0;
    m.priority_history = HIST_RESET;
    {mf, alt_af, alt_hl, alt_de, alt_bc, m_sw, m_ct} = '0;
  endtask

  // Reference model; condition sees flags from before this command
  task apply(input cmd_s c);
    m_ct = cond_eval(c.cond, mf);
    case (c.op)
      OP_WRITE:
        case (c.sel)
          SEL_ACCUM:         m.accum = c.data[7:0];
          SEL_WIDE_ACCUM:    m.wide_accumulator = c.data;
          SEL_PAIR_SECOND:   m.pair_second = c.data;
          SEL_PAIR_THIRD:    m.pair_third = c.data;
          SEL_INDEX_FIRST:   m.index_first = c.data;
          SEL_INDEX_SECOND:  m.index_second = c.data;
          SEL_STACK_POINTER: m.stack_pointer = c.data;
          SEL_EXT_VEC:       m.external_vector_base = c.data[7:0];
          SEL_INT_VEC:       m.internal_vector_base = c.data[7:0];
          SEL_PRI_HIST:      m.priority_history = c.data[7:0];
          default:           ;
        endcase
      OP_SWAP_AF:     {m.accum, mf, alt_af} = {alt_af, m.accum, mf};
      OP_SWAP_BANK:   {m.wide_accumulator, m.pair_second, m.pair_third, alt_hl, alt_de, alt_bc} =
                      {alt_hl, alt_de, alt_bc, m.wide_accumulator, m.pair_second, m.pair_third};
      OP_STACK_SAVE_ACCUM_FLAGS:     m_sw = {m.accum, mf};
      OP_STACK_LOAD_ACCUM_FLAGS:      {m.accum, mf} = c.data;
      OP_ALU_FLAGS:   mf = (mf & ~c.flag_mask) | (c.flag_value & c.flag_mask);
      OP_PRI_RAISE:   m.priority_history = {m.priority_history[5:0], c.level};
      OP_PRI_RESTORE: m.priority_history = {m.priority_history[1:0], m.priority_history[7:2]};
      default:        ;
    endcase
  endtask

  function automatic cmd_s mk(op_e o, reg_sel_e s, logic [15:0] d);
    mk = '0;
    mk.op = o;
    mk.sel = s;
    mk.data = d;
    mk.flag_mask = 8'($urandom);
    mk.flag_value = 8'($urandom);
    mk.level = 2'($urandom);
    mk.cond = cond_e'(3'($urandom));
  endfunction

  // Driver: the note is queued at the taking edge, checked at the next falling edge
  task do_op(input cmd_s c);
    cmd = c;
    apply(c);
    @(posedge sys_clk);
    notes.push_back('{m, m_sw, m_ct});
    #1;
  endtask

  task report(input logic [127:0] got, input logic [127:0] exp);
    fail_count++;
    $display("wrong value at %0t: got %h expected %h", $time, got, exp);
  endtask

  task cmp_regs(input regs_s got, input regs_s exp);
    cmp_count++;
    if (got !== exp) report(got, exp);
  endtask

  task cmp_word(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) report(128'(got), 128'(exp));
  endtask

  task cmp_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) report(128'(got), 128'(exp));
  endtask

  initial
  begin
    note_s n;
    forever
    begin
      @(negedge sys_clk);
      if (notes.size() > 0)
      begin
        n = notes.pop_front();
        cmp_regs(regs, n.r);
        cmp_word(stack_word, n.w);
        cmp_bit(cond_true, n.c);
      end
    end
  end

  task print_verdict;
    $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Whole run needs about 400 cycles
  initial
  begin
    repeat (3000) @(posedge sys_clk);
    fail_count++;
    print_verdict();
  end

  initial
  begin
    cmd_s c;
    fail_count = 0;
    cmp_count = 0;
    rst = 1'b1;
    cmd = '0;
    model_reset();
    void'($urandom(98678));
    repeat (5) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    do_op(mk(OP_NONE, SEL_ACCUM, 16'h0000));
    for (int i = 0; i < 40; i++)
      do_op(mk(OP_WRITE, reg_sel_e'(4'(i % 10)), 16'($urandom)));
    do_op(mk(OP_WRITE, SEL_STACK_POINTER, 16'hFFFF));
    // Unknown target and unknown op change nothing
    do_op(mk(OP_WRITE, reg_sel_e'(4'hC), 16'h5A5A));
    do_op(mk(op_e'(4'hF), SEL_ACCUM, 16'h5A5A));
    do_op(mk(OP_STACK_LOAD_ACCUM_FLAGS, SEL_ACCUM, 16'hC33A));
    do_op(mk(OP_STACK_SAVE_ACCUM_FLAGS, SEL_ACCUM, 16'h0000));
    for (int i = 0; i < 40; i++)
      do_op(mk(OP_ALU_FLAGS, SEL_ACCUM, 16'h0000));
    for (int i = 0; i < 24; i++)
    begin
      do_op(mk(OP_STACK_LOAD_ACCUM_FLAGS, SEL_ACCUM, 16'($urandom)));
      c = mk(OP_NONE, SEL_ACCUM, 16'h0000);
      c.cond = cond_e'(3'(i % 8));
      do_op(c);
    end
    do_op(mk(OP_STACK_LOAD_ACCUM_FLAGS, SEL_ACCUM, 16'h1234));
    do_op(mk(OP_SWAP_AF, SEL_ACCUM, 16'h0000));
    do_op(mk(OP_STACK_LOAD_ACCUM_FLAGS, SEL_ACCUM, 16'hABCD));
    do_op(mk(OP_STACK_SAVE_ACCUM_FLAGS, SEL_ACCUM, 16'h0000));
    do_op(mk(OP_SWAP_AF, SEL_ACCUM, 16'h0000));
    do_op(mk(OP_STACK_SAVE_ACCUM_FLAGS, SEL_ACCUM, 16'h0000));
    for (int i = 1; i < 4; i++)
      do_op(mk(OP_WRITE, reg_sel_e'(4'(i)), 16'($urandom)));
    do_op(mk(OP_SWAP_BANK, SEL_ACCUM, 16'h0000));
    do_op(mk(OP_WRITE, SEL_WIDE_ACCUM, 16'($urandom)));
    do_op(mk(OP_SWAP_BANK, SEL_ACCUM, 16'h0000));
    do_op(mk(OP_SWAP_BANK, SEL_ACCUM, 16'h0000));
    for (int i = 0; i < 9; i++)
    begin
      c = mk(i < 4 ? OP_PRI_RAISE : OP_PRI_RESTORE, SEL_ACCUM, 16'h0000);
      c.level = 2'(i);
      do_op(c);
    end
    for (int i = 0; i < 200; i++)
      do_op(mk(op_e'(4'($urandom % 9)), reg_sel_e'(4'($urandom % 10)), 16'($urandom)));
    // Reset again in mid-run; wait until the last note is checked
    @(negedge sys_clk);
    @(posedge sys_clk);
    #1;
    rst = 1'b1;
    model_reset();
    @(posedge sys_clk);
    #1;
    rst = 1'b0;
    do_op(mk(OP_NONE, SEL_ACCUM, 16'h0000));
    do_op(mk(OP_PRI_RAISE, SEL_ACCUM, 16'h0000));
    do_op(mk(OP_SWAP_AF, SEL_ACCUM, 16'h0000));
    do_op(mk(OP_NONE, SEL_ACCUM, 16'h0000));
    repeat (2) @(posedge sys_clk);
    print_verdict();
  end
endmodule
